/* File: hw/adc_seq_consts.vh */
// Purpose: Constants shared by the converter sequencer control block
// Assumes: 16-bit register port with 4-bit word address
// Notes:   Offsets are word indices on the register port
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Register offsets
`define OFF_CTL        4'h0
`define OFF_TRG        4'h1
`define OFF_CFG        4'h2
`define OFF_FLAGS      4'h3
`define OFF_ENABLES    4'h4
`define OFF_RES0       4'h8

// Control/status register fields
`define CTL_EN_BIT     0
`define CTL_START_BIT  1
`define CTL_BUSY_BIT   10
`define CTL_CUR_LSB    12
`define CTL_CUR_MSB    14

// Trigger/input select register fields
`define TRG_SMP_LSB    0
`define TRG_SMP_MSB    2
`define TRG_SEL_LSB    4
`define TRG_SEL_MSB    5
`define TRG_MODE_BIT   6
`define TRG_ALIGN_BIT  7
`define TRG_FIRST_LSB  8
`define TRG_FIRST_MSB  10
`define TRG_LAST_LSB   11
`define TRG_LAST_MSB   13
`define TRG_WMASK      16'h3ff7
`define TRG_RESET      16'h0007

// Voltage range field
`define CFG_VR_LSB     0
`define CFG_VR_MSB     1
`define VR_ENABLED     2'h3
`define VR_RESET       2'h0

// Trigger sources
`define TRIG_SOFT      2'h0
`define TRIG_TIMER     2'h1
`define TRIG_EXT       2'h3

// Sampling time is field value plus this many converter clocks
`define SMP_BASE       4'h4

`endif

/* File: hw/adc_sequencer_control.v */
// Purpose: Control, sequencing and status for a 12-bit converter channel
// Assumes: All inputs synchronous to clk_i; conv_tick_i marks one converter clock
// Notes:   The analog core samples while conv_sample_o is high and answers
//          conv_start_o with conv_done_i and conv_data_i
//
// Contract
// - Control bits 14:12 read the input number being converted.
// - After stopping, field keeps last input; zero if highest input finished.
// - Busy forced to 0 when module enable goes to 1.
// - Start 1 begins sampling or arms hardware triggers; 0 asks termination.
// - Start bit never self-clears; rewrite 0 then 1 to restart.
// - Clearing start finishes current conversion, then stops.
// - Control bit 0 gates converter clock and enables operation.
// - After enable cleared, software reads enable back 0 before clock off.
// - First (10:8) and last (13:11) input fields select the range.
// - Alignment 1 puts result in 15:4, 0 puts it in 11:0.
// - Alignment change re-presents all results without altering them.
// - Mode 1 repeats the range continuously, 0 makes one pass.
// - Trigger select: 3 external pin, 1 timer underflow, 0 software.
// - Sampling lasts field value plus four converter clocks.
// - Conversion only runs with voltage range set to 3; code checks it only when taking a trigger, so a running sequence continues.
// - Flags: overwrite in 15:8, completion in 7:0, write 1 clears.
// - Enables match flag positions bit for bit.
// - Each input has a read-only 16-bit result register reset to zero.
// - Load sets completion flag; load over set flag sets overwrite.
// - Inputs converted in ascending order, one pass or until start cleared.
// - Falling edge of external pin starts conversion when armed.

`include "adc_seq_consts.vh"

`default_nettype none

module adc_sequencer_control #(
    parameter [2:0] MAX_INPUT = 3'h7
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        reset_n_i,
    // Register port
    input  wire [3:0]  addr_i,
    input  wire [15:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [15:0] rdata_o,
    // Trigger sources
    input  wire        conv_tick_i,
    input  wire        timer_underflow_i,
    input  wire        external_trigger_pin_i,
    // Analog core
    input  wire        conv_done_i,
    input  wire [11:0] conv_data_i,
    output reg         converter_clock_en_o,
    output reg         conv_sample_o,
    output reg         conv_start_o,
    output reg  [2:0]  conv_channel_o,
    // Interrupt request
    output reg         irq_o
);

    localparam [1:0] ST_IDLE   = 2'd0;
    localparam [1:0] ST_SYNC   = 2'd1;
    localparam [1:0] ST_SAMPLE = 2'd2;
    localparam [1:0] ST_CONV   = 2'd3;

    ////////////////////////////////////////////////////////////////////////
    // Result presentation

    function [15:0] present;
        input [11:0] raw;
        input        left;
        begin
            if (left)
                present = {raw, 4'h0};
            else
                present = {4'h0, raw};
        end
    endfunction

    // Register select decode shared by every write strobe
    function hit;
        input [3:0] addr;
        input [3:0] offs;
        begin
            hit = (addr == offs);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    reg         en_r;
    reg         start_r;
    reg  [15:0] trg_r;
    reg  [1:0]  voltage_range_r;
    reg  [7:0]  cmp_r;
    reg  [7:0]  ovf_r;
    reg  [7:0]  cmp_en_r;
    reg  [7:0]  ovf_en_r;
    reg  [11:0] res_r [0:7];
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg         busy_r;
    reg  [2:0]  ch_r;
    reg  [2:0]  cur_r;
    reg  [3:0]  smp_cnt_r;
    reg         sw_pend_r;
    reg         ext_prev_r;
    reg  [15:0] rdata_nxt;
    reg  [2:0]  chan_nxt;

    wire [2:0] smp_sel   = trg_r[`TRG_SMP_MSB:`TRG_SMP_LSB];
    wire [1:0] trig_sel  = trg_r[`TRG_SEL_MSB:`TRG_SEL_LSB];
    wire       cont_mode = trg_r[`TRG_MODE_BIT];
    wire       align_l   = trg_r[`TRG_ALIGN_BIT];
    wire [2:0] first_in  = trg_r[`TRG_FIRST_MSB:`TRG_FIRST_LSB];
    wire [2:0] last_in   = trg_r[`TRG_LAST_MSB:`TRG_LAST_LSB];

    wire wr_ctl   = wr_i && hit(addr_i, `OFF_CTL);
    wire wr_trg   = wr_i && hit(addr_i, `OFF_TRG);
    wire wr_cfg   = wr_i && hit(addr_i, `OFF_CFG);
    wire wr_flags = wr_i && hit(addr_i, `OFF_FLAGS);
    wire wr_enab  = wr_i && hit(addr_i, `OFF_ENABLES);

    wire start_wr1 = wr_ctl && wdata_i[`CTL_START_BIT];

    // Trigger events per source; the reserved code never fires
    wire ext_fall = ext_prev_r && !external_trigger_pin_i;
    reg  trig_ev;
    always @* begin
        case (trig_sel)
            `TRIG_SOFT:  trig_ev = sw_pend_r;
            `TRIG_TIMER: trig_ev = timer_underflow_i;
            `TRIG_EXT:   trig_ev = ext_fall;
            default:     trig_ev = 1'b0;
        endcase
    end

    // Accept only while idle, enabled, armed and in the working voltage range
    wire trig_take = trig_ev && start_r && !busy_r && en_r
                     && (voltage_range_r == `VR_ENABLED);

    wire smp_last  = ({1'b0, smp_sel} + `SMP_BASE - 4'h1) == smp_cnt_r;
    wire load_w    = (state_r == ST_CONV) && conv_done_i;
    wire at_last   = (ch_r == last_in);
    wire [7:0] load_vec = load_w ? (8'h01 << ch_r) : 8'h00;
    wire [2:0] stop_ch  = (ch_r == MAX_INPUT) ? 3'h0 : ch_r;

    ////////////////////////////////////////////////////////////////////////
    // Software-owned settings

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_r     <= 1'b0;
            start_r  <= 1'b0;
            trg_r    <= `TRG_RESET;
            voltage_range_r <= `VR_RESET;
        end else begin
            if (wr_ctl) begin
                en_r    <= wdata_i[`CTL_EN_BIT];
                start_r <= wdata_i[`CTL_START_BIT];
            end
            if (wr_trg)
                trg_r <= wdata_i & `TRG_WMASK;
            if (wr_cfg)
                voltage_range_r <= wdata_i[`CFG_VR_MSB:`CFG_VR_LSB];
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmp_en_r <= 8'h00;
            ovf_en_r <= 8'h00;
        end else if (wr_enab) begin
            ovf_en_r <= wdata_i[15:8];
            cmp_en_r <= wdata_i[7:0];
        end
    end

    // Reset to the idle high level so no false edge follows reset
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            ext_prev_r <= 1'b1;
        else
            ext_prev_r <= external_trigger_pin_i;
    end

    // Only a 0-to-1 write of start is a software trigger; a stale one is
    // dropped once another source is chosen, so it cannot fire later
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            sw_pend_r <= 1'b0;
        else if (start_wr1 && !start_r)
            sw_pend_r <= 1'b1;
        else if ((wr_ctl && !wdata_i[`CTL_START_BIT]) || trig_take || (trig_sel != `TRIG_SOFT))
            sw_pend_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (trig_take)
                    state_nxt = ST_SYNC;
            end
            ST_SYNC: begin
                if (conv_tick_i)
                    state_nxt = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                if (conv_tick_i && smp_last)
                    state_nxt = ST_CONV;
            end
            ST_CONV: begin
                if (load_w) begin
                    if (!start_r)
                        state_nxt = ST_IDLE;
                    else if (at_last && !cont_mode)
                        state_nxt = ST_IDLE;
                    else
                        state_nxt = ST_SYNC;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Losing the enable drops the sequence at once; its result is lost.
        // Setting the enable also passes through here, so busy starts at 0.
        if (!en_r)
            state_nxt = ST_IDLE;
    end

    // Channel shown to the core: held while idle, next input on each load
    always @* begin
        chan_nxt = ch_r;
        if (state_nxt == ST_IDLE)
            chan_nxt = conv_channel_o;
        else if (state_r == ST_IDLE)
            chan_nxt = first_in;
        else if (load_w && !at_last)
            chan_nxt = ch_r + 3'h1;
        else if (load_w)
            chan_nxt = first_in;
    end

    // Counts converter clocks only while sampling
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            smp_cnt_r <= 4'h0;
        else if (state_r != ST_SAMPLE)
            smp_cnt_r <= 4'h0;
        else if (conv_tick_i)
            smp_cnt_r <= smp_cnt_r + 4'h1;
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r        <= ST_IDLE;
            busy_r         <= 1'b0;
            ch_r           <= 3'h0;
            cur_r          <= 3'h0;
            conv_sample_o  <= 1'b0;
            conv_start_o   <= 1'b0;
            conv_channel_o <= 3'h0;
        end else begin
            state_r      <= state_nxt;
            busy_r       <= (state_nxt != ST_IDLE);
            conv_sample_o <= (state_nxt == ST_SAMPLE);
            conv_start_o <= (state_r == ST_SAMPLE) && (state_nxt == ST_CONV);
            if (state_r == ST_IDLE && trig_take) begin
                ch_r  <= first_in;
                cur_r <= first_in;
            end else if (load_w && state_nxt == ST_SYNC) begin
                ch_r  <= at_last ? first_in : ch_r + 3'h1;
                cur_r <= at_last ? first_in : ch_r + 3'h1;
            end else if (load_w) begin
                cur_r <= stop_ch;
            end
            conv_channel_o <= chan_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results and event flags

    // One result slot and one flag pair per input
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : slot
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i)
                    res_r[g] <= 12'h000;
                else if (load_vec[g])
                    res_r[g] <= conv_data_i;
            end
            // A load in the same cycle as a clear keeps the flag set
            always @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cmp_r[g] <= 1'b0;
                    ovf_r[g] <= 1'b0;
                end else begin
                    if (load_vec[g])
                        cmp_r[g] <= 1'b1;
                    else if (wr_flags && wdata_i[g])
                        cmp_r[g] <= 1'b0;
                    if (load_vec[g] && cmp_r[g])
                        ovf_r[g] <= 1'b1;
                    else if (wr_flags && wdata_i[g + 8])
                        ovf_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else
            irq_o <= |((cmp_r & cmp_en_r) | (ovf_r & ovf_en_r));
    end

    // Gate follows the enable register one clock later; clearing it stops the core on the next clock
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            converter_clock_en_o <= 1'b0;
        else
            converter_clock_en_o <= en_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data stand only in the cycle after the strobe

    always @* begin
        rdata_nxt = 16'h0000;
        if (rd_i) begin
            if (addr_i >= `OFF_RES0)
                rdata_nxt = present(res_r[addr_i[2:0]], align_l);
            else begin
                case (addr_i)
                    `OFF_CTL: begin
                        rdata_nxt[`CTL_CUR_MSB:`CTL_CUR_LSB] = cur_r;
                        rdata_nxt[`CTL_BUSY_BIT]  = busy_r;
                        rdata_nxt[`CTL_START_BIT] = start_r;
                        rdata_nxt[`CTL_EN_BIT]    = en_r;
                    end
                    `OFF_TRG:     rdata_nxt = trg_r;
                    `OFF_CFG:     rdata_nxt[`CFG_VR_MSB:`CFG_VR_LSB] = voltage_range_r;
                    `OFF_FLAGS:   rdata_nxt = {ovf_r, cmp_r};
                    `OFF_ENABLES: rdata_nxt = {ovf_en_r, cmp_en_r};
                    default:      rdata_nxt = 16'h0000;
                endcase
            end
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            rdata_o <= 16'h0000;
        else
            rdata_o <= rdata_nxt;
    end

endmodule

`default_nettype wire

/* File: tb/adc_core_model.sv */
// Purpose: Analog core and converter clock model for the sequencer
// Assumes: One converter clock tick every DIV system clocks
// Notes:   Data lines toggle when idle so a late sample never matches
`default_nettype none
module adc_core_model #(
    parameter int DIV = 3,
    parameter int LAT = 5
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        start_i,
    input  wire logic [2:0]  ch_i,
    input  wire logic [7:0]  base_i,
    output logic             tick_o,
    output logic             done_o,
    output logic [11:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int          dv;
    int          lt;
    logic [11:0] val;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dv <= 0;
            lt <= 0;
            val <= 12'h000;
            tick_o <= 1'b0;
            done_o <= 1'b0;
            data_o <= 12'h000;
        end else begin
            dv <= (dv == DIV - 1) ? 0 : dv + 1;
            tick_o <= (dv == DIV - 1);
            done_o <= (lt == 1);
            data_o <= (lt == 1) ? val : ~data_o;
            if (start_i) begin
                lt <= LAT;
                val <= {ch_i, 1'b0, base_i};
            end else if (lt != 0) begin
                lt <= lt - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/adc_sequencer_control_props.sv */
// Purpose: Port-level checks of the converter sequencer
// Assumes: Settings change only while idle, so shadows track them
// Notes:   Shadows mirror trigger and range writes
`default_nettype none
module adc_seq_props #(
    parameter [2:0] MAX_INPUT = 3'h7
) (
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [3:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        conv_tick_i,
    input wire logic        converter_clock_en_o,
    input wire logic        conv_sample_o,
    input wire logic        conv_start_o,
    input wire logic [2:0]  conv_channel_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] trg_r;
    logic [1:0]  vr_r;
    logic [3:0]  cnt_r;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            trg_r <= 16'h0007;
            vr_r <= 2'h0;
            cnt_r <= 4'h0;
        end else begin
            if (wr_i && addr_i == 4'h1) trg_r <= wdata_i & 16'h3ff7;
            if (wr_i && addr_i == 4'h2) vr_r <= wdata_i[1:0];
            cnt_r <= conv_sample_o ? cnt_r + {3'h0, conv_tick_i} : 4'h0;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_clk_gate_follow: assert property (
        (wr_i && addr_i == 4'h0) ##1 !(wr_i && addr_i == 4'h0) |=> converter_clock_en_o == $past(wdata_i[0], 2))
        else $error("clock gate does not follow enable");
    a_start_pulse: assert property (conv_start_o |=> !conv_start_o) else $error("start too long");
    a_sample_ends: assert property (
        conv_start_o |-> $past(conv_sample_o) && !conv_sample_o) else $error("start without sampling");
    a_sample_len: assert property (
        conv_start_o |-> cnt_r == trg_r[2:0] + 4'h4) else $error("sampling length wrong");
    a_range_gate: assert property (
        $rose(conv_sample_o) |-> vr_r == 2'h3 && converter_clock_en_o) else $error("ran while blocked");
    a_channel_range: assert property (
        conv_start_o |-> conv_channel_o >= trg_r[10:8] && conv_channel_o <= trg_r[13:11])
        else $error("channel outside range");
    a_channel_steady: assert property (
        conv_sample_o && $past(conv_sample_o) |-> $stable(conv_channel_o)) else $error("channel moved");
    a_channel_max: assert property (conv_start_o |-> conv_channel_o <= MAX_INPUT) else $error("channel too high");
    cover property (conv_start_o);
    cover property ($rose(irq_o));
    cover property (wr_i && addr_i == 4'h3);
endmodule
bind adc_sequencer_control adc_seq_props #(.MAX_INPUT(MAX_INPUT)) props_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .conv_tick_i(conv_tick_i), .converter_clock_en_o(converter_clock_en_o), .conv_sample_o(conv_sample_o),
    .conv_start_o(conv_start_o), .conv_channel_o(conv_channel_o), .irq_o(irq_o)
);
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Core model answers every start
// Notes:   Start is held low long enough between passes
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [3:0]  addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        tmr = 1'b0;
    logic        pin = 1'b1;
    logic [7:0]  base = 8'h5a;
    wire  [15:0] rdata_o;
    wire  [11:0] data;
    wire  [2:0]  ch;
    wire         tick, done, clk_en, smp, start, irq;
    int          n_fail = 0;
    int          cmp_count = 0;
    logic [2:0]  chq[$];
    adc_sequencer_control dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .conv_tick_i(tick), .timer_underflow_i(tmr),
        .external_trigger_pin_i(pin), .conv_done_i(done), .conv_data_i(data), .converter_clock_en_o(clk_en),
        .conv_sample_o(smp), .conv_start_o(start), .conv_channel_o(ch), .irq_o(irq));
    adc_core_model core_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(start), .ch_i(ch), .base_i(base),
        .tick_o(tick), .done_o(done), .data_o(data));
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (start === 1'b1) chq.push_back(ch);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask
    task automatic rc(input string nm, input logic [3:0] a, input logic [15:0] e);
        logic [15:0] d;
        rd(a, d);
        chk(nm, d, e);
    endtask
    // Start low must outlast two converter clocks
    task automatic halt();
        wr(4'h0, 16'h0001);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wait_idle();
        int i;
        logic [15:0] d;
        d = 16'hffff;
        for (i = 0; i < 300 && (d[10] !== 1'b0 || i < 2); i++) rd(4'h0, d);
        chk("busy clears", {15'h0, d[10]}, 16'h0000);
    endtask
    task automatic pulse_tmr();
        @(posedge clk_i);
        tmr <= 1'b1;
        @(posedge clk_i);
        tmr <= 1'b0;
    endtask
    task automatic t_reset();
        rc("trg reset", 4'h1, 16'h0007);
        rc("flag reset", 4'h3, 16'h0000);
        rc("res reset", 4'hf, 16'h0000);
        wr(4'h5, 16'hffff);
        rc("unmapped", 4'h5, 16'h0000);
        wr(4'hf, 16'hffff);
        rc("res ro", 4'hf, 16'h0000);
        wr(4'h1, 16'hffff);
        rc("trg mask", 4'h1, 16'h3ff7);
    endtask
    task automatic t_oneshot();
        int i;
        wr(4'h0, 16'h0001);
        wr(4'h1, 16'h2200);
        wr(4'h2, 16'h0003);
        wr(4'h4, 16'h00ff);
        chq.delete();
        wr(4'h0, 16'h0003);
        wait_idle();
        chk("order", {1'b0, chq[0], 1'b0, chq[1], 1'b0, chq[2], 4'h0}, 16'h2340);
        for (i = 2; i < 5; i++) rc("result", 4'(8 + i), {4'h0, 3'(i), 1'b0, base});
        rc("flags", 4'h3, 16'h001c);
        rc("ctl done", 4'h0, 16'h4003);
        chk("irq", {15'h0, irq}, 16'h0001);
        wr(4'h1, 16'h2280);
        rc("left", 4'ha, {3'h2, 1'b0, base, 4'h0});
        wr(4'h1, 16'h2200);
        repeat (60) @(posedge clk_i);
        chk("no restart", 16'(chq.size()), 16'h3);
    endtask
    task automatic t_overwrite();
        base <= 8'h33;
        halt();
        wr(4'h0, 16'h0003);
        wait_idle();
        rc("ovr flags", 4'h3, 16'h1c1c);
        rc("newest", 4'hb, {4'h0, 3'h3, 1'b0, 8'h33});
        wr(4'h3, 16'h1c00);
        rc("w1c", 4'h3, 16'h001c);
        wr(4'h4, 16'hff00);
        rc("enables", 4'h4, 16'hff00);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        wr(4'h3, 16'h001c);
        rc("cleared", 4'h3, 16'h0000);
    endtask
    task automatic t_triggers();
        halt();
        wr(4'h1, 16'h3f15);
        wr(4'h0, 16'h0003);
        repeat (40) @(posedge clk_i);
        rc("armed idle", 4'h0, 16'h4003);
        pulse_tmr();
        wait_idle();
        rc("top wraps", 4'h0, 16'h0003);
        rc("timer res", 4'hf, {4'h0, 3'h7, 1'b0, base});
        halt();
        wr(4'h1, 16'h3f35);
        wr(4'h0, 16'h0003);
        chq.delete();
        @(posedge clk_i);
        pin <= 1'b0;
        repeat (2) @(posedge clk_i);
        pin <= 1'b1;
        wait_idle();
        chk("ext start", 16'(chq.size()), 16'h1);
        halt();
        wr(4'h1, 16'h3f25);
        wr(4'h0, 16'h0003);
        pulse_tmr();
        pin <= 1'b0;
        repeat (60) @(posedge clk_i);
        pin <= 1'b1;
        chk("reserved", 16'(chq.size()), 16'h1);
    endtask
    task automatic t_cont_abort();
        int i;
        logic [2:0] c;
        halt();
        wr(4'h1, 16'h0840);
        chq.delete();
        wr(4'h0, 16'h0003);
        repeat (300) @(posedge clk_i);
        for (i = 0; i < 100 && smp !== 1'b1; i++) @(posedge clk_i);
        c = ch;
        base <= 8'h77;
        wr(4'h0, 16'h0001);
        wait_idle();
        chk("repeats", {15'h0, chq.size() >= 4}, 16'h0001);
        chk("finished", {13'h0, chq[$]}, {13'h0, c});
        rc("last res", 4'(8 + c), {4'h0, c, 1'b0, 8'h77});
        wr(4'h1, 16'h0000);
        wr(4'h0, 16'h0003);
        for (i = 0; i < 100 && smp !== 1'b1; i++) @(posedge clk_i);
        wr(4'h0, 16'h0000);
        rc("aborted", 4'h0, 16'h0000);
        chk("clock off", {15'h0, clk_en}, 16'h0000);
        wr(4'h0, 16'h0001);
        rc("busy reset", 4'h0, 16'h0001);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_oneshot();
        t_overwrite();
        t_triggers();
        t_cont_abort();
        tally_and_finish();
    end
    // Whole run is about a thousand cycles; this limit is 50000 cycles, some fifty times that
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
